// ---- nth_pkg.sv ----
package nth_pkg;
    // ****************************************
    // header layout
    // ****************************************
    localparam int HDR_BASE_BYTES = 10;
    localparam int HDR_NUMBUF_BYTES = 2;
    localparam int HDR_HASH_BYTES = 2;
    localparam int FLAG_NEEDS_CSUM = 0;
    localparam int FLAG_DATA_VALID = 1;
    localparam int FLAG_RSC_INFO = 2;
    localparam logic [7:0] GSO_ECN_MASK = 8'h80;
    localparam logic [6:0] GSO_NONE = 7'h00;
    localparam logic [6:0] GSO_TCPV4 = 7'h01;
    localparam logic [6:0] GSO_UDP = 7'h03;
    localparam logic [6:0] GSO_TCPV6 = 7'h04;
    localparam logic [6:0] GSO_UDP_L4 = 7'h05;
    localparam logic [15:0] PLAIN_FRAME_MAX = 16'h05ea;
    localparam int FIFO_DEPTH = 8;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] gso_type;
        logic [15:0] hdr_len;
        logic [15:0] gso_size;
        logic [15:0] csum_start;
        logic [15:0] csum_offset;
    } nth_hdr_t;

    typedef struct packed {
        logic legacy;
        logic big_endian;
        logic mrg_rxbuf;
        logic hash_report;
        logic host_ecn;
        logic guest_hdrlen;
    } nth_cfg_t;

    typedef struct packed {
        logic csum_en;
        logic [15:0] csum_start;
        logic [15:0] csum_pos;
        logic seg_en;
        logic [6:0] seg_kind;
        logic ecn;
        logic [15:0] seg_size;
        logic [15:0] seg_hdr_len;
        logic hdr_len_exact;
        logic [15:0] pkt_len;
    } nth_desc_t;

    typedef enum logic [1:0] {
        ST_HDR = 2'b00,
        ST_BODY = 2'b01,
        ST_EMIT = 2'b11
    } nth_state_t;
endpackage

// ---- nth_fifo.sv ----
`timescale 1ns/1ps
module nth_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;
    logic valid_reg, valid_next;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = cnt_reg != (AW+1)'(DEPTH);
    assign out_valid = valid_reg;
    assign out_data = mem[rd_reg];

    always_comb begin
        wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
        rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
        cnt_next = cnt_reg;
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
        valid_next = cnt_next != '0;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
            valid_reg <= valid_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
endmodule

// ---- nth_tx_header.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - flags and gso_type bytes, five le16 fields, optional hash word
// - legacy mode uses guest native byte order for multi-byte fields
// - legacy without merged buffers: no num_buffers, two bytes shorter
// - needs-csum: checksum from csum_start, stored csum_offset beyond it
// - segmentation accepts packets over 1514 bytes, split at gso_size
// - bit 0x80 of gso_type is the ecn marker with host ecn
// - unknown flag bits are ignored
// - without needs-csum, csum fields unused and checksum not trusted
// - hdr_len exact only with guest hdrlen and segmentation, else hint
module nth_tx_header (
    input wire logic sys_clk,
    input wire logic rst,
    input wire nth_pkg::nth_cfg_t cfg,
    input wire logic [7:0] in_byte,
    input wire logic in_valid,
    input wire logic in_last,
    output logic in_ready,
    output nth_pkg::nth_desc_t desc,
    output logic desc_valid,
    input wire logic desc_ready,
    output logic long_plain_err
);
    // ****************************************
    // header parse
    // ****************************************
    nth_pkg::nth_state_t st_reg, st_next;
    logic [4:0] idx_reg, idx_next;
    logic [79:0] raw_reg, raw_next;
    logic [15:0] len_reg, len_next;
    logic err_reg, err_next;
    nth_pkg::nth_desc_t d_next;
    nth_pkg::nth_hdr_t h;
    logic [4:0] hdr_bytes;
    logic fifo_in_ready;
    logic take;
    logic in_ready_reg, in_ready_next;

    function automatic logic [15:0] fld(input logic [15:0] w,
                                        input logic swap);
        fld = swap ? {w[7:0], w[15:8]} : {w[15:8], w[7:0]};
    endfunction

    always_comb begin
        hdr_bytes = 5'(nth_pkg::HDR_BASE_BYTES);
        if (!cfg.legacy || cfg.mrg_rxbuf) begin
            hdr_bytes = hdr_bytes + 5'(nth_pkg::HDR_NUMBUF_BYTES);
        end
        if (cfg.hash_report) begin
            hdr_bytes = hdr_bytes + 5'(nth_pkg::HDR_HASH_BYTES);
        end
    end

    always_comb begin
        logic sw;
        sw = cfg.legacy && cfg.big_endian;
        h.flags = raw_reg[7:0];
        h.gso_type = raw_reg[15:8];
        h.hdr_len = fld(raw_reg[31:16], sw);
        h.gso_size = fld(raw_reg[47:32], sw);
        h.csum_start = fld(raw_reg[63:48], sw);
        h.csum_offset = fld(raw_reg[79:64], sw);
    end

    assign take = in_valid && in_ready;
    assign in_ready = in_ready_reg;

    always_comb begin
        st_next = st_reg;
        idx_next = idx_reg;
        raw_next = raw_reg;
        len_next = len_reg;
        err_next = 1'b0;
        case (st_reg)
            nth_pkg::ST_HDR: begin
                if (take) begin
                    if (idx_reg < 5'(nth_pkg::HDR_BASE_BYTES)) begin
                        raw_next[idx_reg*8 +: 8] = in_byte;
                    end
                    idx_next = idx_reg + 1'b1;
                    len_next = '0;
                    if (in_last) begin
                        st_next = nth_pkg::ST_EMIT;
                    end else if (idx_reg == hdr_bytes - 1'b1) begin
                        st_next = nth_pkg::ST_BODY;
                    end
                end
            end
            nth_pkg::ST_BODY: begin
                if (take) begin
                    len_next = len_reg + 1'b1;
                    if (in_last) begin
                        st_next = nth_pkg::ST_EMIT;
                    end
                end
            end
            nth_pkg::ST_EMIT: begin
                if (fifo_in_ready) begin
                    st_next = nth_pkg::ST_HDR;
                    idx_next = '0;
                    raw_next = '0;
                    err_next = !d_next.seg_en &&
                               len_reg > nth_pkg::PLAIN_FRAME_MAX;
                end
            end
            default: begin
                st_next = nth_pkg::ST_HDR;
            end
        endcase
        in_ready_next = st_next != nth_pkg::ST_EMIT;
    end

    // ****************************************
    // descriptor build
    // ****************************************
    always_comb begin
        logic [6:0] kind;
        kind = h.gso_type[6:0];
        d_next.csum_en = h.flags[nth_pkg::FLAG_NEEDS_CSUM];
        // csum fields masked when not requested
        d_next.csum_start = d_next.csum_en ? h.csum_start : '0;
        d_next.csum_pos = d_next.csum_en ?
                          16'(h.csum_start + h.csum_offset) : '0;
        d_next.seg_en = kind == nth_pkg::GSO_TCPV4 ||
                        kind == nth_pkg::GSO_UDP ||
                        kind == nth_pkg::GSO_TCPV6 ||
                        kind == nth_pkg::GSO_UDP_L4;
        d_next.seg_kind = d_next.seg_en ? kind : nth_pkg::GSO_NONE;
        d_next.ecn = cfg.host_ecn &&
                     (h.gso_type & nth_pkg::GSO_ECN_MASK) != 8'h00;
        d_next.seg_size = d_next.seg_en ? h.gso_size : '0;
        d_next.seg_hdr_len = h.hdr_len;
        // exact only with guest hdrlen and segmentation
        d_next.hdr_len_exact = cfg.guest_hdrlen && d_next.seg_en;
        d_next.pkt_len = len_reg;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_reg <= nth_pkg::ST_HDR;
            idx_reg <= '0;
            raw_reg <= '0;
            len_reg <= '0;
            err_reg <= 1'b0;
            in_ready_reg <= 1'b1;
        end else begin
            st_reg <= st_next;
            idx_reg <= idx_next;
            raw_reg <= raw_next;
            len_reg <= len_next;
            err_reg <= err_next;
            in_ready_reg <= in_ready_next;
        end
    end

    assign long_plain_err = err_reg;

    // ****************************************
    // output fifo
    // ****************************************
    nth_fifo #(
        .WIDTH($bits(nth_pkg::nth_desc_t)),
        .DEPTH(nth_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_data(d_next),
        .in_valid(st_reg == nth_pkg::ST_EMIT),
        .in_ready(fifo_in_ready),
        .out_data(desc),
        .out_valid(desc_valid),
        .out_ready(desc_ready)
    );

    // ****************************************
    // checks
    // ****************************************
    // no csum position without flag
    chk_csum_masked: assert property (@(posedge sys_clk) disable iff (rst)
        desc_valid && !desc.csum_en |-> desc.csum_pos == 16'h0000)
        else $error("csum fields leaked");
    chk_seg_plain: assert property (@(posedge sys_clk) disable iff (rst)
        desc_valid && !desc.seg_en |-> desc.seg_size == 16'h0000)
        else $error("seg size on plain packet");
    chk_hdr_exact: assert property (@(posedge sys_clk) disable iff (rst)
        desc_valid && desc.hdr_len_exact |-> desc.seg_en)
        else $error("hdr_len exact without seg");
    chk_ecn_gate: assert property (@(posedge sys_clk) disable iff (rst)
        !cfg.host_ecn |-> !d_next.ecn)
        else $error("ecn without host ecn");
    chk_hdr_size: assert property (@(posedge sys_clk) disable iff (rst)
        cfg.legacy && !cfg.mrg_rxbuf && !cfg.hash_report |->
        hdr_bytes == 5'd10)
        else $error("legacy header size wrong");
    chk_csum_pos: assert property (@(posedge sys_clk) disable iff (rst)
        d_next.csum_en |-> d_next.csum_pos ==
        16'(h.csum_start + h.csum_offset))
        else $error("csum position wrong");
    chk_emit_after: assert property (@(posedge sys_clk) disable iff (rst)
        take && in_last |=> st_reg == nth_pkg::ST_EMIT)
        else $error("no emit after last");
    chk_flag_ignore: assert property (@(posedge sys_clk) disable iff (rst)
        d_next.csum_en == h.flags[0])
        else $error("flag decode wrong");
    cov_seg: cover property (@(posedge sys_clk) desc_valid && desc.seg_en);
    cov_csum: cover property (@(posedge sys_clk) desc_valid && desc.csum_en);
    cov_full: cover property (@(posedge sys_clk) !fifo_in_ready);
    cov_err: cover property (@(posedge sys_clk) long_plain_err);
endmodule

// ---- nth_drv_model.sv ----
`timescale 1ns/1ps
// ****************************************
// guest driver feeding the transmit stream
// ****************************************
module nth_drv_model (
    input wire logic sys_clk,
    input wire logic in_ready,
    output logic [7:0] in_byte,
    output logic in_valid,
    output logic in_last
);
    logic ok;
    // no completion length is read back
    initial begin
        in_byte = 8'h00;
        in_valid = 1'b0;
        in_last = 1'b0;
    end
    // header then body as one unit
    task automatic send(input logic [7:0] q[$], input int gap);
        for (int i = 0; i < q.size(); i++) begin
            in_byte = q[i];
            in_valid = 1'b1;
            in_last = (i == q.size() - 1);
            forever begin
                ok = in_ready;
                @(posedge sys_clk);
                #1;
                if (ok === 1'b1) break;
            end
            if (gap > 0 || i == q.size() - 1) begin
                in_valid = 1'b0;
                in_last = 1'b0;
                in_byte = ~in_byte;
                repeat (gap) begin
                    @(posedge sys_clk);
                    #1;
                end
            end
        end
    endtask
endmodule

// ---- net_tx_header_offload_bench.sv ----
`timescale 1ns/1ps
module net_tx_header_offload_bench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    nth_pkg::nth_cfg_t cfg = '0;
    logic [7:0] in_byte;
    logic in_valid, in_last, in_ready, desc_valid, long_plain_err;
    logic desc_ready = 1'b0;
    logic hold = 1'b0;
    nth_pkg::nth_desc_t desc;
    nth_pkg::nth_desc_t exp_q[$];
    int errors = 0, n_tests = 0, n_err = 0, exp_err = 0, cyc = 0;
    integer seed = 32'h03b7;
    logic [6:0] codes[6] = '{7'h00, 7'h01, 7'h03, 7'h04, 7'h05, 7'h02};

    always #25 sys_clk = ~sys_clk;

    nth_tx_header i_dut (.sys_clk(sys_clk), .rst(rst), .cfg(cfg),
        .in_byte(in_byte), .in_valid(in_valid), .in_last(in_last),
        .in_ready(in_ready), .desc(desc), .desc_valid(desc_valid),
        .desc_ready(desc_ready), .long_plain_err(long_plain_err));
    nth_drv_model i_drv (.sys_clk(sys_clk), .in_ready(in_ready),
        .in_byte(in_byte), .in_valid(in_valid), .in_last(in_last));

    task automatic print_verdict();
        if (errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic check_desc(input nth_pkg::nth_desc_t e);
        chk(desc.csum_en, e.csum_en);
        chk(desc.csum_pos, e.csum_pos);
        if (e.csum_en) chk(desc.csum_start, e.csum_start);
        chk(desc.seg_en, e.seg_en);
        if (e.seg_en) chk(desc.seg_kind, e.seg_kind);
        if (e.seg_en) chk(desc.seg_size, e.seg_size);
        chk(desc.ecn, e.ecn);
        chk(desc.seg_hdr_len, e.seg_hdr_len);
        chk(desc.hdr_len_exact, e.hdr_len_exact);
        chk(desc.pkt_len, e.pkt_len);
    endtask

    // ****************************************
    // one packet: header bytes, body, model
    // ****************************************
    task automatic pkt(input logic [7:0] fl, input logic [6:0] code,
                       input int len, input logic [5:0] c);
        logic [7:0] q[$];
        logic [15:0] f[6];
        logic [15:0] v;
        nth_pkg::nth_desc_t e;
        int nf;
        repeat (3) @(posedge sys_clk);
        #1;
        while (in_ready !== 1'b1) begin
            @(posedge sys_clk);
            #1;
        end
        cfg = nth_pkg::nth_cfg_t'(c);
        nf = (cfg.legacy && !cfg.mrg_rxbuf) ? 4 : 5;
        nf += cfg.hash_report;
        f[0] = 16'($random(seed));
        f[1] = 16'($random(seed));
        f[2] = {8'h00, 8'($random(seed))};
        f[3] = {8'h00, 8'($random(seed))};
        f[4] = 16'h0000;
        f[5] = 16'h0000;
        // receive bits clear, any nonzero gso code sets csum
        fl = (fl & 8'hf9) | {7'h00, code != 7'h00};
        // random marker, gated by host ecn
        q.push_back(fl);
        q.push_back({1'($random(seed)), code});
        for (int i = 0; i < nf; i++) begin
            v = (cfg.legacy && cfg.big_endian) ?
                {f[i][7:0], f[i][15:8]} : f[i];
            q.push_back(v[7:0]);
            q.push_back(v[15:8]);
        end
        repeat (len) q.push_back(8'($random(seed)));
        e = '0;
        e.csum_en = fl[0];
        e.csum_start = fl[0] ? f[2] : 16'h0000;
        e.csum_pos = fl[0] ? f[2] + f[3] : 16'h0000;
        e.seg_kind = code;
        e.seg_en = code inside {7'h01, 7'h03, 7'h04, 7'h05};
        e.ecn = q[1][7] & cfg.host_ecn;
        e.seg_size = f[1];
        e.seg_hdr_len = f[0];
        e.hdr_len_exact = cfg.guest_hdrlen & e.seg_en;
        e.pkt_len = 16'(len);
        if (!e.seg_en && len > 1514) exp_err++;
        exp_q.push_back(e);
        i_drv.send(q, len % 2);
    endtask

    always @(posedge sys_clk) begin
        #1;
        desc_ready = !hold && ($random(seed) % 3 != 0);
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (long_plain_err === 1'b1) n_err++;
        if (desc_valid === 1'b1 && desc_ready === 1'b1) begin
            if (exp_q.size() == 0) chk(16'h0001, 16'h0000);
            else check_desc(exp_q.pop_front());
        end
        if (cyc == 30000) begin
            errors++;
            print_verdict();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        @(posedge sys_clk);
        #1;
        chk(in_ready, 1'b1);
        chk(desc_valid, 1'b0);
        @(posedge sys_clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 42; i++) begin
            pkt(8'($random(seed)), codes[i % 6], i % 13, 6'($random(seed)));
        end
        pkt(8'h00, 7'h00, 1514, 6'($random(seed)));
        pkt(8'h00, 7'h00, 1515, 6'($random(seed)));
        pkt(8'h01, 7'h01, 1600, 6'($random(seed)));
        hold = 1'b1;
        fork
            for (int k = 0; k < 10; k++) pkt(8'h01, 7'h00, 3, 6'h00);
        join_none
        repeat (300) @(posedge sys_clk);
        #1;
        chk(in_ready, 1'b0);
        chk(desc_valid, 1'b1);
        hold = 1'b0;
        wait fork;
        for (int k = 0; k < 300 && exp_q.size() != 0; k++) begin
            @(posedge sys_clk);
        end
        #1;
        chk(16'(exp_q.size()), 16'h0000);
        chk(16'(n_err), 16'(exp_err));
        print_verdict();
    end
endmodule
